/* File: hdl/rpc_pkg.sv */
// How it works
// - Control registers at 01h-18h, channels 1-24
// - Trunk code registers at 21h-38h, one each
// - Signaling trunk registers at 41h-58h, one each
// - Channel select works only when global select zero
// - Select 001 sends the channel trunk code
// - Select 010 sends the A-law milliwatt pattern
// - Select 011 sends the mu-law milliwatt pattern
// - Flips 000 pass; 001 flips bits 2,4,6,8
// - Flips 010 invert bits 3,5,7 only
// - Flips 011 invert bits 2 through 8
// - Flips 100 invert the MSB only
// - Flips 101 invert MSB plus even bits
// - Flips 110 invert bits 1,3,5,7
// - Flips 111 invert all eight bits
// - Clock blanking needs master mode and enable bit
// - No blanking controls set gives every pulse
// - LSB blanking drops the bit 8 pulse
// - Whole blanking drops every pulse of channel
package rpc_pkg;
    // Channel count and register address space
    localparam int CH_NUM = 24;
    localparam int ADDR_W = 7;
    localparam logic [ADDR_W-1:0] CTRL_BASE = 7'h01;
    localparam logic [ADDR_W-1:0] CTRL_LAST = 7'h18;
    localparam logic [ADDR_W-1:0] TRUNK_BASE = 7'h21;
    localparam logic [ADDR_W-1:0] TRUNK_LAST = 7'h38;
    localparam logic [ADDR_W-1:0] SIG_BASE = 7'h41;
    localparam logic [ADDR_W-1:0] SIG_LAST = 7'h58;
    localparam logic [ADDR_W-1:0] GSEL_ADDR = 7'h60;
    localparam logic [ADDR_W-1:0] GCLK_ADDR = 7'h61;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 7'h62;
    // Channel control field positions
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int MSBF_BIT = 4;
    localparam int ODDF_BIT = 3;
    localparam int EVENF_BIT = 2;
    localparam int LSBG_BIT = 1;
    localparam int ALLG_BIT = 0;
    // Global clock control fields
    localparam int SLOT_CLK_EN_BIT = 0;
    localparam int MASTER_BIT = 1;
    // Replacement select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_TRUNK = 3'h1;
    localparam logic [2:0] SEL_ALAW = 3'h2;
    localparam logic [2:0] SEL_MULAW = 3'h3;
    // Inversion masks, bit 1 of the channel is data bit 7
    localparam logic [7:0] MASK_MSB = 8'h80;
    localparam logic [7:0] MASK_ODD = 8'h2a;
    localparam logic [7:0] MASK_EVEN = 8'h55;
    // Reset value and stored bits of signaling trunk register
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SIG_MASK = 8'h5f;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Word passed through the buffer toward the backplane
    typedef struct packed {
        logic first;
        logic gapAll;
        logic gapLsb;
        logic [7:0] data;
    } rpc_word_t;
    // Serializer states
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SHIFT = 2'b10
    } rpc_ser_t;
endpackage

/* File: hdl/rpc_top.sv */
`timescale 1ns/1ps
// Word buffer between channel processing and the serializer
module rpc_fifo #(
    parameter int W = 11,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData,
    output logic [$clog2(D):0] level
);
    // Pointer width and wrap points
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
    localparam logic [AW-1:0] LAST_IDX = AW'(D-1);

    // Storage and indices
    logic [W-1:0] mem [D]; // Storage array
    logic [AW-1:0] wrPtr_r; // Write index
    logic [AW-1:0] rdPtr_r; // Read index
    logic [AW:0] cnt_r; // Words held
    logic [AW:0] cntNxt; // Next count, also feeds ready
    logic ready_r; // Registered not-full

    // Push and pop both qualified by clock enable
    wire push = ce && inValid && ready_r;
    wire pop = ce && outReady && (cnt_r != '0);

    // Count follows push and pop
    always_comb begin
        // Holds when both or neither move
        cntNxt = cnt_r;
        if (push && !pop) begin
            // One word in
            cntNxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            // One word out
            cntNxt = cnt_r - 1'b1;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Empty, and not ready until released
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
        end else if (ce) begin
            // Write index wraps at the last slot
            if (push) begin
                wrPtr_r <= (wrPtr_r == LAST_IDX) ? '0 : wrPtr_r + 1'b1;
            end
            // Read index wraps at the last slot
            if (pop) begin
                rdPtr_r <= (rdPtr_r == LAST_IDX) ? '0 : rdPtr_r + 1'b1;
            end
            // Ready drops once the last free slot fills
            cnt_r <= cntNxt;
            ready_r <= (cntNxt != FULL_CNT);
        end
    end

    // Data write, no reset: only written words are read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Head word shown while count is nonzero
    assign inReady = ready_r;
    assign outValid = (cnt_r != '0);
    assign outData = mem[rdPtr_r];
    assign level = cnt_r;
endmodule

// Receive payload control: substitution, inversion, clock blanking
module rpc_top #(
    parameter int DEPTH = 16,
    parameter logic [0:7][7:0] ALAW_SEQ = {8'h34, 8'h21, 8'h21, 8'h34,
        8'hb4, 8'ha1, 8'ha1, 8'hb4},
    parameter logic [0:7][7:0] MULAW_SEQ = {8'h1e, 8'h0b, 8'h0b, 8'h1e,
        8'h9e, 8'h8b, 8'h8b, 8'h9e}
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [rpc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic inValid,
    output logic inReady,
    input wire logic [7:0] inData,
    input wire logic inFirst,
    input wire logic outReady,
    output logic outValid,
    output logic outBit,
    output logic outClk,
    output logic outFirst
);
    // Level width and wrap point of the channel count
    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [4:0] LAST_CH = 5'(rpc_pkg::CH_NUM - 1);

    // Address range check shared by read and write decode
    function automatic logic inRange(input logic [rpc_pkg::ADDR_W-1:0] a,
        input logic [rpc_pkg::ADDR_W-1:0] lo, input logic [rpc_pkg::ADDR_W-1:0] hi);
        // Both bounds inclusive
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // Inversion mask from the three flip controls
    function automatic logic [7:0] flipMask(input logic m, input logic o, input logic e);
        // Masks combine by OR, so all eight settings come out
        flipMask = (m ? rpc_pkg::MASK_MSB : 8'h00) | (o ? rpc_pkg::MASK_ODD : 8'h00)
            | (e ? rpc_pkg::MASK_EVEN : 8'h00);
    endfunction

    // Register banks, one entry per channel
    logic [7:0] ctrl_r [rpc_pkg::CH_NUM]; // Channel control registers
    logic [7:0] trunk_r [rpc_pkg::CH_NUM]; // Data trunk codes
    logic [7:0] sig_r [rpc_pkg::CH_NUM]; // Signaling trunk codes
    // Global controls and bus answer
    logic [2:0] gsel_r; // Global replace select
    logic slotClkEn_r; // Per-slot clock control enable
    logic master_r; // Receive clock master mode
    logic [7:0] rdData_r; // Read answer
    // Stream position and buffer state
    logic [4:0] chan_r; // Last accepted channel
    logic [2:0] phase_r; // Milliwatt phase, advances per frame
    logic [LW-1:0] level; // Buffer fill level

    // Register decode
    wire hitCtrl = inRange(regAddr, rpc_pkg::CTRL_BASE, rpc_pkg::CTRL_LAST);
    wire hitTrunk = inRange(regAddr, rpc_pkg::TRUNK_BASE, rpc_pkg::TRUNK_LAST);
    wire hitSig = inRange(regAddr, rpc_pkg::SIG_BASE, rpc_pkg::SIG_LAST);
    // Index within a bank, used only on a hit
    wire [4:0] idxCtrl = 5'(regAddr - rpc_pkg::CTRL_BASE);
    wire [4:0] idxTrunk = 5'(regAddr - rpc_pkg::TRUNK_BASE);
    wire [4:0] idxSig = 5'(regAddr - rpc_pkg::SIG_BASE);
    // Global registers sit above the banks
    wire hitGsel = (regAddr == rpc_pkg::GSEL_ADDR);
    wire hitGclk = (regAddr == rpc_pkg::GCLK_ADDR);
    wire hitStat = (regAddr == rpc_pkg::STAT_ADDR);

    // Read selection, unmapped addresses answer zero
    wire [7:0] rdMux = hitCtrl ? ctrl_r[idxCtrl]
        : hitTrunk ? trunk_r[idxTrunk]
        : hitSig ? sig_r[idxSig]
        : hitGsel ? {5'h00, gsel_r}
        : hitGclk ? {6'h00, master_r, slotClkEn_r}
        : hitStat ? 8'(level)
        : 8'h00;

    // Per-channel register writes
    generate
        for (genvar c = 0; c < rpc_pkg::CH_NUM; c++) begin : gChan
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    // All banks clear to zero
                    ctrl_r[c] <= rpc_pkg::REG_RESET;
                    trunk_r[c] <= rpc_pkg::REG_RESET;
                    sig_r[c] <= rpc_pkg::REG_RESET;
                end else if (ce && regWrStb) begin
                    // One address hits one channel only
                    if (hitCtrl && idxCtrl == 5'(c)) begin
                        ctrl_r[c] <= regWrData;
                    end
                    // Trunk code bank
                    if (hitTrunk && idxTrunk == 5'(c)) begin
                        trunk_r[c] <= regWrData;
                    end
                    // Signaling bank keeps its stored bits only
                    if (hitSig && idxSig == 5'(c)) begin
                        sig_r[c] <= regWrData & rpc_pkg::SIG_MASK;
                    end
                end
            end
        end
    endgenerate

    // Global registers and read answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Globals clear, read answer idle
            gsel_r <= 3'h0;
            slotClkEn_r <= 1'b0;
            master_r <= 1'b0;
            rdData_r <= 8'h00;
        end else if (ce) begin
            // Global select, status writes fall through
            if (regWrStb && hitGsel) begin
                gsel_r <= regWrData[2:0];
            end
            // Clock mode bits
            if (regWrStb && hitGclk) begin
                slotClkEn_r <= regWrData[rpc_pkg::SLOT_CLK_EN_BIT];
                master_r <= regWrData[rpc_pkg::MASTER_BIT];
            end
            // Answer stands one cycle, then zero
            rdData_r <= regRdStb ? rdMux : 8'h00;
        end
    end

    // Channel position of the incoming byte
    wire inReadyW;
    wire accept = ce && inValid && inReadyW;
    // Frame start forces channel one, otherwise wrap after the last
    wire [4:0] chanNow = inFirst ? 5'h00 : ((chan_r == LAST_CH) ? 5'h00 : chan_r + 1'b1);
    wire [7:0] chCtrl = ctrl_r[chanNow];
    // A frame start byte already uses the next phase
    wire [2:0] phaseNow = inFirst ? phase_r + 1'b1 : phase_r;

    // Effective select: global code overrides channel code
    // Channel code counts only while the global code is zero
    wire [2:0] chSel = chCtrl[rpc_pkg::SEL_MSB:rpc_pkg::SEL_LSB];
    wire [2:0] effSel = (gsel_r != rpc_pkg::SEL_NONE) ? gsel_r : chSel;

    // Replacement; reserved codes pass data through
    wire [7:0] substData = (effSel == rpc_pkg::SEL_TRUNK) ? trunk_r[chanNow]
        : (effSel == rpc_pkg::SEL_ALAW) ? ALAW_SEQ[phaseNow]
        : (effSel == rpc_pkg::SEL_MULAW) ? MULAW_SEQ[phaseNow]
        : inData;

    // Inversion mask, covers all eight flip settings
    // Applied after substitution, to replaced data as well
    wire [7:0] invMask = flipMask(chCtrl[rpc_pkg::MSBF_BIT], chCtrl[rpc_pkg::ODDF_BIT],
        chCtrl[rpc_pkg::EVENF_BIT]);
    wire [7:0] procData = substData ^ invMask;

    // Blanking qualifies only in master mode with enable set
    wire gapOn = master_r && slotClkEn_r;
    wire gapAllW = gapOn && chCtrl[rpc_pkg::ALLG_BIT];
    wire gapLsbW = gapOn && chCtrl[rpc_pkg::LSBG_BIT] && !chCtrl[rpc_pkg::ALLG_BIT];

    // Processed byte travels with its blanking flags
    rpc_pkg::rpc_word_t inWord;
    assign inWord = '{first: inFirst, gapAll: gapAllW, gapLsb: gapLsbW, data: procData};

    // Channel counter and milliwatt phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Start at the last channel, first byte is one
            chan_r <= LAST_CH;
            phase_r <= 3'h0;
        end else if (accept) begin
            // Move only on an accepted byte
            chan_r <= chanNow;
            // Phase moves on at each frame start
            if (inFirst) begin
                phase_r <= phaseNow;
            end
        end
    end

    // Buffer toward the backplane
    // Head word and its valid flag
    rpc_pkg::rpc_word_t fWord;
    wire fValid;
    wire fPop;
    rpc_fifo #(.W($bits(rpc_pkg::rpc_word_t)), .D(DEPTH)) uFifo (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .inValid(inValid),
        .inReady(inReadyW),
        .inData(inWord),
        .outValid(fValid),
        .outReady(fPop),
        .outData(fWord),
        .level(level)
    );

    // Serializer state
    rpc_pkg::rpc_ser_t ser_r;
    rpc_pkg::rpc_ser_t serNxt;
    rpc_pkg::rpc_word_t cur_r; // Word being shifted
    logic [2:0] bit_r; // Index of bit on the line
    // Registered line outputs
    logic outValid_r;
    logic outBit_r;
    logic outClk_r;
    logic outFirst_r;

    // One bit slot per cycle with outReady; load at end of word
    wire atEnd = (ser_r == rpc_pkg::SER_IDLE) || (bit_r == rpc_pkg::LAST_BIT);
    // Pop only at a word end
    assign fPop = outReady && atEnd;
    wire load = fPop && fValid;
    // Mid word, each ready cycle moves one bit
    wire advance = outReady && !atEnd;
    // Load takes the head word, else keep the current one
    rpc_pkg::rpc_word_t nextWord;
    assign nextWord = load ? fWord : cur_r;
    wire [2:0] nextBit = load ? 3'h0 : bit_r + 1'b1;
    // MSB leaves the line first
    wire nextBitVal = nextWord.data[3'(rpc_pkg::LAST_BIT - nextBit)];
    // Blanked bits still take a slot, only the pulse is dropped
    wire nextPulse = !(nextWord.gapAll
        || (nextWord.gapLsb && nextBit == rpc_pkg::LAST_BIT));

    // Next serializer state
    always_comb begin
        serNxt = ser_r;
        unique case (ser_r)
            rpc_pkg::SER_IDLE: begin
                // Start as soon as a word is ready
                if (load) begin
                    serNxt = rpc_pkg::SER_SHIFT;
                end
            end
            rpc_pkg::SER_SHIFT: begin
                // Rest when the buffer runs dry at a word end
                if (outReady && atEnd && !fValid) begin
                    serNxt = rpc_pkg::SER_IDLE;
                end
            end
            default: begin
                // Illegal codes recover to idle
                serNxt = rpc_pkg::SER_IDLE;
            end
        endcase
    end

    // Line outputs, timing held for blanked bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Quiet line during reset
            ser_r <= rpc_pkg::SER_IDLE;
            cur_r <= '0;
            bit_r <= 3'h0;
            outValid_r <= 1'b0;
            outBit_r <= 1'b0;
            outClk_r <= 1'b0;
            outFirst_r <= 1'b0;
        end else if (ce) begin
            // State always follows
            ser_r <= serNxt;
            // Slot filled: bit and pulse flag for one cycle
            if (load || advance) begin
                cur_r <= nextWord;
                bit_r <= nextBit;
                outValid_r <= 1'b1;
                outBit_r <= nextBitVal;
                outClk_r <= nextPulse;
                outFirst_r <= nextWord.first && (nextBit == 3'h0);
            end else begin
                // No slot this cycle, line quiet
                outValid_r <= 1'b0;
                outClk_r <= 1'b0;
                outFirst_r <= 1'b0;
            end
        end
    end

    // Top outputs straight from flip-flops
    assign regRdData = rdData_r;
    assign inReady = inReadyW;
    assign outValid = outValid_r;
    assign outBit = outBit_r;
    assign outClk = outClk_r;
    assign outFirst = outFirst_r;
endmodule

/* File: bench/rpc_checker.sv */
`timescale 1ns/1ps
// Port checks for the payload block
module rpc_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic outReady,
    input wire logic outValid,
    input wire logic outClk,
    input wire logic outFirst
);
    logic [2:0] bitCnt_r; // Slots seen in this word
    logic [2:0] bitCnt_nxt; // Slots including this cycle
    wire logic inCt; // Control or trunk address
    wire logic inSig; // Signaling trunk address
    assign bitCnt_nxt = bitCnt_r + {2'h0, outValid};
    assign inCt = (regAddr >= rpc_pkg::CTRL_BASE && regAddr <= rpc_pkg::CTRL_LAST)
        || (regAddr >= rpc_pkg::TRUNK_BASE && regAddr <= rpc_pkg::TRUNK_LAST);
    assign inSig = regAddr >= rpc_pkg::SIG_BASE && regAddr <= rpc_pkg::SIG_LAST;
    // Slot counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bitCnt_r <= 3'h0;
        end else begin
            bitCnt_r <= bitCnt_nxt;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_rd_idle;
        !$past(regRdStb) |-> regRdData == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        regRdStb && !inCt && !inSig && regAddr < rpc_pkg::GSEL_ADDR |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole read not zero");
    property p_wr_rd_ct;
        regWrStb && inCt ##1 regRdStb && $stable(regAddr) |=> regRdData == $past(regWrData, 2);
    endproperty
    a_wr_rd_ct: assert property (p_wr_rd_ct) else $error("readback wrong");
    property p_wr_rd_sig;
        regWrStb && inSig ##1 regRdStb && $stable(regAddr)
            |=> regRdData == ($past(regWrData, 2) & rpc_pkg::SIG_MASK);
    endproperty
    a_wr_rd_sig: assert property (p_wr_rd_sig) else $error("sig readback wrong");
    property p_mid_word;
        bitCnt_nxt != 3'h0 && outReady |=> outValid;
    endproperty
    a_mid_word: assert property (p_mid_word) else $error("slot skipped");
    property p_valid_src;
        outValid |-> $past(outReady);
    endproperty
    a_valid_src: assert property (p_valid_src) else $error("bit without slot");
    property p_first_pos;
        outFirst |-> bitCnt_r == 3'h0 && outValid;
    endproperty
    a_first_pos: assert property (p_first_pos) else $error("marker misplaced");
    property p_first_gap;
        outFirst |=> (!outFirst) [*7];
    endproperty
    a_first_gap: assert property (p_first_gap) else $error("marker too close");
    property p_clk_valid;
        outClk |-> outValid;
    endproperty
    a_clk_valid: assert property (p_clk_valid) else $error("pulse outside slot");
endmodule

/* File: bench/rpc_backplane.sv */
`timescale 1ns/1ps
// Backplane model: takes serial bits, regroups them into bytes
module rpc_backplane (
    input wire logic clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic outValid,
    input wire logic outBit,
    input wire logic outClk,
    input wire logic outFirst,
    output logic outReady = 1'b0,
    output logic wordStb = 1'b0,
    output logic [16:0] word
);
    integer seed = 37; // Fixed seed for stalls
    logic [2:0] cnt_r = 3'h0; // Slot within the byte
    logic [6:0] dat_r; // Bits so far, first highest
    logic [6:0] ck_r; // Pulse flags so far
    logic fst_r; // Channel one marker
    // Random ready, byte assembly
    always @(posedge clk) begin
        outReady <= rstn && !stall && ($random(seed) % 3 != 0);
        wordStb <= 1'b0;
        if (!rstn) begin
            cnt_r <= 3'h0;
        end else if (outValid) begin
            // Blanked slots still hold a bit place
            cnt_r <= cnt_r + 3'h1;
            dat_r <= {dat_r[5:0], outBit};
            ck_r <= {ck_r[5:0], outClk};
            if (cnt_r == 3'h0) begin
                fst_r <= outFirst;
            end
            if (cnt_r == 3'h7) begin
                wordStb <= 1'b1;
                word <= {fst_r, ck_r, outClk, dat_r, outBit};
            end
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
// Bench for the receive payload control block
module tb_top;
    localparam logic [0:7][7:0] ALAW = {8'h34, 8'h21, 8'h21, 8'h34, 8'hb4, 8'ha1, 8'ha1, 8'hb4};
    localparam logic [0:7][7:0] MULAW = {8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic regWrStb = 1'b0, regRdStb = 1'b0, inValid = 1'b0, inFirst = 1'b0, stall = 1'b0;
    logic ce = 1'b1; // Clock enable, dropped once to check the freeze
    logic [6:0] regAddr = 7'h00;
    logic [7:0] regWrData = 8'h00, inData = 8'h00, regRdData;
    logic inReady, outReady, outValid, outBit, outClk, outFirst, wordStb;
    logic [16:0] word;
    logic [7:0] ctrlS [1:24]; // Shadow control
    logic [7:0] trunkS [1:24]; // Shadow trunk codes
    logic [2:0] gselS = 3'h0;
    logic [1:0] gclkS = 2'h0;
    logic [16:0] expQ [$]; // Words owed
    logic [6:0] holes [6] = '{7'h00, 7'h19, 7'h20, 7'h39, 7'h40, 7'h59};
    integer nMismatch = 0, testsRun = 0, seed = 37, ch = 24, frameCnt = 0, k;
    // Clock, 4 ns
    initial begin
        forever #2 clk = ~clk;
    end
    rpc_top #(.DEPTH(16), .ALAW_SEQ(ALAW), .MULAW_SEQ(MULAW)) rpc_top_inst (
        .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .inValid(inValid),
        .inReady(inReady), .inData(inData), .inFirst(inFirst), .outReady(outReady),
        .outValid(outValid), .outBit(outBit), .outClk(outClk), .outFirst(outFirst)
    );
    rpc_backplane rpc_backplane_inst (
        .clk(clk), .rstn(rstn), .stall(stall), .outValid(outValid), .outBit(outBit),
        .outClk(outClk), .outFirst(outFirst), .outReady(outReady), .wordStb(wordStb), .word(word)
    );
    // Compare and count
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict
    task automatic reportAndStop();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Register read, data one cycle later
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        @(posedge clk);
        chk({9'h000, regRdData}, {9'h000, e});
    endtask
    // Write then read back
    task automatic wrRd(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        rd(a, e);
    endtask
    // Expected word: marker, pulse flags, data
    function automatic logic [16:0] expWord(input logic [7:0] d, input logic [7:0] c,
            input logic [7:0] t, input int ph);
        logic [7:0] v;
        logic [7:0] ck;
        case ((gselS != 3'h0) ? gselS : c[7:5])
            3'h1: v = t;
            3'h2: v = ALAW[ph];
            3'h3: v = MULAW[ph];
            default: v = d;
        endcase
        // Flip mask, bit 1 highest
        v = v ^ {c[4], c[2], c[3], c[2], c[3], c[2], c[3], c[2]};
        ck = (gclkS != 2'h3) ? 8'hff : (c[0] ? 8'h00 : (c[1] ? 8'hfe : 8'hff));
        return {ch == 1, ck, v};
    endfunction
    // Send one byte, queue its word
    task automatic sendByte(input logic f);
        logic [7:0] d;
        d = 8'($random(seed));
        frameCnt = frameCnt + f;
        ch = (f || ch == 24) ? 1 : ch + 1;
        expQ.push_back(expWord(d, ctrlS[ch], trunkS[ch], frameCnt % 8));
        inValid <= 1'b1;
        inData <= d;
        inFirst <= f;
        k = 0;
        @(posedge clk);
        while (!inReady && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k == 200) begin
            chk(17'h1, 17'h0);
            reportAndStop();
        end
    endtask
    // Collected words against expectation
    always @(posedge clk) begin
        if (wordStb) begin
            chk(word, expQ.size() != 0 ? expQ.pop_front() : ~word);
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        // Reset values across all three banks
        for (int i = 1; i <= 24; i++) begin
            rd(rpc_pkg::CTRL_BASE + 7'(i - 1), 8'h00);
            rd(rpc_pkg::TRUNK_BASE + 7'(i - 1), 8'h00);
            rd(rpc_pkg::SIG_BASE + 7'(i - 1), 8'h00);
            ctrlS[i] = 8'h00;
            trunkS[i] = 8'h00;
        end
        // Gaps between banks ignore writes
        foreach (holes[j]) begin
            wrRd(holes[j], 8'hff, 8'h00);
        end
        // Write with clock enable low leaves the register alone
        ce <= 1'b0;
        regAddr <= rpc_pkg::CTRL_BASE;
        regWrData <= 8'hff;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        ce <= 1'b1;
        @(posedge clk);
        rd(rpc_pkg::CTRL_BASE, 8'h00);
        // Fill buffer with the far side stalled
        stall <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            sendByte(i == 0);
        end
        inValid <= 1'b0;
        repeat (2) @(posedge clk);
        chk({16'h0000, inReady}, 17'h0);
        wrRd(rpc_pkg::STAT_ADDR, 8'h00, 8'h10);
        stall <= 1'b0;
        // Frames: even ones sweep every code, one frame cut short
        for (int f = 0; f < 7; f++) begin
            gselS = (f == 3) ? 3'h1 : ((f == 4) ? 3'h2 : ((f == 6) ? 3'h3 : 3'h0));
            gclkS = (f == 1) ? 2'h1 : ((f == 5) ? 2'h2 : 2'h3);
            wrRd(rpc_pkg::GSEL_ADDR, {5'h00, gselS}, {5'h00, gselS});
            wrRd(rpc_pkg::GCLK_ADDR, {6'h00, gclkS}, {6'h00, gclkS});
            for (int c = 1; c <= 24; c++) begin
                ctrlS[c] = (f % 2 == 1) ? 8'($random(seed)) : {3'(c - 1), 3'(c - 1), 2'($random(seed))};
                trunkS[c] = 8'($random(seed));
                wrRd(rpc_pkg::CTRL_BASE + 7'(c - 1), ctrlS[c], ctrlS[c]);
                wrRd(rpc_pkg::TRUNK_BASE + 7'(c - 1), trunkS[c], trunkS[c]);
                wrRd(rpc_pkg::SIG_BASE + 7'(c - 1), 8'hff - trunkS[c], (8'hff - trunkS[c]) & rpc_pkg::SIG_MASK);
            end
            for (int c = 0; c < ((f == 5) ? 10 : 24); c++) begin
                sendByte(c == 0);
            end
            inValid <= 1'b0;
        end
        k = 0;
        while (expQ.size() != 0 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        chk(17'(expQ.size()), 17'h0);
        // Second reset clears control
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(rpc_pkg::CTRL_LAST, 8'h00);
        reportAndStop();
    end
endmodule
bind rpc_top rpc_checker rpc_checker_inst (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .outReady(outReady), .outValid(outValid),
    .outClk(outClk), .outFirst(outFirst)
);
